// ### rtl/qrgs_sequencer.sv
// Gate sequencer for a dual low-side PWM controller, APB register slave.
// Assumes asynchronous comparator pins; they are synchronised here.
// Notes on behaviour
// - Each gate gated by own enable.
// - Dead time inserted before any turn-on.
// - Current sense blanked after primary turn-on.
// - Demag comparator routed in or ignored.
// - Quasi-resonant: demag restarts each cycle.
// - Watchdog bit makes period timer restart cycle.
// - Peak fall: primary off, dead, secondary on.
// - Secondary on fires 200 ns clear pulse.
// - Demag edges ignored during clear pulse.
// - Demag fall sets flop, fires 33 ns.
// - No clear pulse: timer keeps running.
// - Peak trip latches primary off until cycle.
// - Period from timer and period limit.
// - Primary on-time capped by max duty.
// - Offset adjust code drives current offset.
// - Fixed period is clock divided by N.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module qrgs_sequencer
   import qrgs_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Comparator pins
   input wire logic peak_compare,
   input wire logic demag_compare,
   // Gate drives and analog controls
   output logic primary_gate_out,
   output logic secondary_gate_out,
   output logic sense_blank,
   output logic [7:0] offset_adjust_code
);

   // Registers
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [3:0] dead_q, dead_d;
   logic [1:0] blank_sel_q, blank_sel_d;
   logic [7:0] offset_q, offset_d;
   logic [7:0] period_q, period_d;
   logic [7:0] maxduty_q, maxduty_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;

   // Synchronisers and edge history
   logic [1:0] peak_sync_q, demag_sync_q;
   logic peak_prev_q, demag_prev_q;

   // Sequencer
   qrgs_state_type state_q, state_d;
   logic [7:0] timer_q, timer_d;
   logic [7:0] on_cnt_q, on_cnt_d;
   logic [3:0] dead_cnt_q, dead_cnt_d;
   logic [1:0] blank_cnt_q, blank_cnt_d;
   logic cycle_ff_q, cycle_ff_d;
   logic off_latch_q, off_latch_d;
   logic pri_q, pri_d;
   logic sec_q, sec_d;
   logic blank_q, blank_d;

   // Decoded terms
   logic access, wr, known, peak_fall, demag_fall, start_evt;
   logic [7:0] limit;

   qrgs_shot_if clear_shot ();
   qrgs_shot_if start_shot ();

   qrgs_oneshot #(.WIDTH(SHOT_CLEAR_CYC)) u_clear_shot (
      .pclk(pclk),
      .presetn(presetn),
      .shot(clear_shot)
   );

   qrgs_oneshot #(.WIDTH(SHOT_START_CYC)) u_start_shot (
      .pclk(pclk),
      .presetn(presetn),
      .shot(start_shot)
   );

   function automatic logic [1:0] blank_cycles(input logic [1:0] sel);
      logic [1:0] c;
      c = 2'h0;
      unique case (sel)
         2'h0: c = 2'h0;
         2'h1: c = BLANK1_CYC;
         2'h2: c = BLANK2_CYC;
         2'h3: c = BLANK3_CYC;
      endcase
      return c;
   endfunction : blank_cycles

   function automatic logic addr_known(input logic [7:0] a);
      return (a == OFF_CTRL) || (a == OFF_DEAD) || (a == OFF_BLANK) ||
             (a == OFF_OFFSET) || (a == OFF_PERIOD) || (a == OFF_MAXDUTY) ||
             (a == OFF_STATUS);
   endfunction : addr_known

   // Register slave: one wait state, answer on the second access cycle
   always_comb begin
      access = psel & penable & ~pready_q;
      // Write lands on the edge that completes the transfer
      wr = psel & penable & pready_q & pwrite;
      known = addr_known(paddr);
      ctrl_d = ctrl_q;
      dead_d = dead_q;
      blank_sel_d = blank_sel_q;
      offset_d = offset_q;
      period_d = period_q;
      maxduty_d = maxduty_q;
      prdata_d = prdata_q;
      pready_d = access;
      pslverr_d = access & ~known;
      if (wr) begin
         unique case (paddr)
            OFF_CTRL: ctrl_d = pwdata[CTRL_W-1:0];
            OFF_DEAD: dead_d = pwdata[3:0];
            OFF_BLANK: blank_sel_d = pwdata[1:0];
            OFF_OFFSET: offset_d = pwdata[7:0];
            OFF_PERIOD: period_d = pwdata[7:0];
            OFF_MAXDUTY: maxduty_d = pwdata[7:0];
            default: ;
         endcase
      end
      if (access & ~pwrite) begin
         unique case (paddr)
            OFF_CTRL: prdata_d = {28'h0000000, ctrl_q};
            OFF_DEAD: prdata_d = {28'h0000000, dead_q};
            OFF_BLANK: prdata_d = {30'h00000000, blank_sel_q};
            OFF_OFFSET: prdata_d = {24'h000000, offset_q};
            OFF_PERIOD: prdata_d = {24'h000000, period_q};
            OFF_MAXDUTY: prdata_d = {24'h000000, maxduty_q};
            OFF_STATUS: prdata_d = {13'h0000, state_q, timer_q,
                                    3'h0, blank_q, off_latch_q, cycle_ff_q, sec_q, pri_q};
            default: prdata_d = 32'h00000000;
         endcase
      end
   end

   // Sequencer next state
   always_comb begin
      limit = (period_q < PERIOD_MIN) ? PERIOD_MIN : period_q;
      peak_fall = peak_prev_q & ~peak_sync_q[1];
      demag_fall = demag_prev_q & ~demag_sync_q[1];
      // Noise right after secondary turn-on must not restart the cycle
      start_shot.trig = ctrl_q[CTRL_QR_MODE] & demag_fall & ~clear_shot.pulse;
      state_d = state_q;
      timer_d = timer_q + 8'h01;
      on_cnt_d = on_cnt_q;
      dead_cnt_d = dead_cnt_q;
      blank_cnt_d = blank_cnt_q;
      cycle_ff_d = cycle_ff_q;
      off_latch_d = off_latch_q;
      clear_shot.trig = 1'b0;

      if (ctrl_q[CTRL_QR_MODE]) begin
         // Period timer restarts on the clear pulse or on reaching the limit, else it counts up
         if (clear_shot.pulse || timer_q >= limit) begin
            timer_d = 8'h00;
         end
         start_evt = start_shot.pulse |
                     (ctrl_q[CTRL_WDE] & timer_q >= limit & ~clear_shot.pulse);
      end else begin
         if (timer_q >= limit) begin
            timer_d = 8'h00;
         end
         start_evt = timer_q >= limit;
      end

      if (start_shot.trig) begin
         cycle_ff_d = 1'b1;
      end else if (clear_shot.pulse) begin
         cycle_ff_d = 1'b0;
      end
      if (start_evt) begin
         off_latch_d = 1'b0;
      end
      if (blank_cnt_q != 2'h0) begin
         blank_cnt_d = blank_cnt_q - 2'h1;
      end

      unique case (state_q)
         ST_IDLE, ST_SEC_ON: begin
            if (start_evt) begin
               state_d = ST_PRI_DEAD;
               dead_cnt_d = dead_q;
            end
         end
         ST_PRI_DEAD: begin
            if (dead_cnt_q != 4'h0) begin
               dead_cnt_d = dead_cnt_q - 4'h1;
            end else if (!off_latch_q) begin
               state_d = ST_PRI_ON;
               on_cnt_d = 8'h00;
               blank_cnt_d = blank_cycles(blank_sel_q);
            end
         end
         ST_PRI_ON: begin
            on_cnt_d = on_cnt_q + 8'h01;
            if ((peak_fall && blank_cnt_q == 2'h0) || on_cnt_q >= maxduty_q) begin
               state_d = ST_SEC_DEAD;
               dead_cnt_d = dead_q;
               off_latch_d = 1'b1;
            end
         end
         ST_SEC_DEAD: begin
            if (dead_cnt_q != 4'h0) begin
               dead_cnt_d = dead_cnt_q - 4'h1;
            end else begin
               state_d = ST_SEC_ON;
               clear_shot.trig = 1'b1;
            end
         end
         default: state_d = ST_IDLE;
      endcase

      // Pin follows the mask window exactly, no trailing cycle
      blank_d = blank_cnt_d != 2'h0;
      pri_d = ctrl_q[CTRL_PRI_EN] & (state_d == ST_PRI_ON);
      sec_d = ctrl_q[CTRL_SEC_EN] & (state_d == ST_SEC_ON);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         dead_q <= DEAD_RST;
         blank_sel_q <= BLANK_RST;
         offset_q <= OFFSET_RST;
         period_q <= PERIOD_RST;
         maxduty_q <= MAXDUTY_RST;
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         peak_sync_q <= 2'h0;
         demag_sync_q <= 2'h3;
         peak_prev_q <= 1'b0;
         demag_prev_q <= 1'b1;
         state_q <= ST_IDLE;
         timer_q <= 8'h00;
         on_cnt_q <= 8'h00;
         dead_cnt_q <= 4'h0;
         blank_cnt_q <= 2'h0;
         cycle_ff_q <= 1'b0;
         off_latch_q <= 1'b0;
         pri_q <= 1'b0;
         sec_q <= 1'b0;
         blank_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         dead_q <= dead_d;
         blank_sel_q <= blank_sel_d;
         offset_q <= offset_d;
         period_q <= period_d;
         maxduty_q <= maxduty_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         peak_sync_q <= {peak_sync_q[0], peak_compare};
         demag_sync_q <= {demag_sync_q[0], demag_compare};
         peak_prev_q <= peak_sync_q[1];
         demag_prev_q <= demag_sync_q[1];
         state_q <= state_d;
         timer_q <= timer_d;
         on_cnt_q <= on_cnt_d;
         dead_cnt_q <= dead_cnt_d;
         blank_cnt_q <= blank_cnt_d;
         cycle_ff_q <= cycle_ff_d;
         off_latch_q <= off_latch_d;
         pri_q <= pri_d;
         sec_q <= sec_d;
         blank_q <= blank_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign primary_gate_out = pri_q;
   assign secondary_gate_out = sec_q;
   assign sense_blank = blank_q;
   assign offset_adjust_code = offset_q;

endmodule : qrgs_sequencer

// ### pkg/qrgs_pkg.sv
// Package for the quasi-resonant gate sequencer: register map, fields,
// reset values, timing constants and sequencer states.
// Assumes a 10 MHz pclk; all times are converted to pclk cycles here.
package qrgs_pkg;

   // Bus clock
   localparam int CLK_PERIOD_NS = 100;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_DEAD = 8'h04;
   localparam logic [7:0] OFF_BLANK = 8'h08;
   localparam logic [7:0] OFF_OFFSET = 8'h0C;
   localparam logic [7:0] OFF_PERIOD = 8'h10;
   localparam logic [7:0] OFF_MAXDUTY = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   // Control register bit positions
   localparam int CTRL_PRI_EN = 0;
   localparam int CTRL_SEC_EN = 1;
   localparam int CTRL_QR_MODE = 2;
   localparam int CTRL_WDE = 3;
   localparam int CTRL_W = 4;

   // Reset values
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [3:0] DEAD_RST = 4'h0;
   localparam logic [1:0] BLANK_RST = 2'h0;
   localparam logic [7:0] OFFSET_RST = 8'h00;
   localparam logic [7:0] PERIOD_RST = 8'hFF;
   localparam logic [7:0] MAXDUTY_RST = 8'h80;

   // Period limit holds N-1; N is kept at 4 or above
   localparam logic [7:0] PERIOD_MIN = 8'h03;

   // One-shot widths: least times, rounded up to whole cycles
   localparam int SHOT_CLEAR_NS = 200;
   localparam int SHOT_START_NS = 33;
   localparam int SHOT_CLEAR_CYC = (SHOT_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHOT_START_CYC = (SHOT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Blanking choices in ns, rounded up to cycles
   localparam int BLANK1_NS = 50;
   localparam int BLANK2_NS = 100;
   localparam int BLANK3_NS = 200;
   localparam logic [1:0] BLANK1_CYC = 2'((BLANK1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] BLANK2_CYC = 2'((BLANK2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] BLANK3_CYC = 2'((BLANK3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PRI_DEAD = 3'b001,
      ST_PRI_ON = 3'b010,
      ST_SEC_DEAD = 3'b011,
      ST_SEC_ON = 3'b100
   } qrgs_state_type;

endpackage : qrgs_pkg

// ### pkg/qrgs_shot_if.sv
// Trigger and pulse of one fixed-width one-shot.
// The generator drives pulse; the user drives trig.
`timescale 1ns/1ps
interface qrgs_shot_if;
   logic trig;
   logic pulse;
   modport gen (input trig, output pulse);
   modport user (output trig, input pulse);
endinterface : qrgs_shot_if

// ### rtl/qrgs_oneshot.sv
// Retriggerable one-shot of a fixed number of pclk cycles.
// Assumes trig is a single-cycle pulse on pclk.
`timescale 1ns/1ps
module qrgs_oneshot
   import qrgs_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Trigger and pulse
   qrgs_shot_if.gen shot
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic pulse_q;
   logic pulse_d;

   always_comb begin
      cnt_d = cnt_q;
      if (shot.trig) begin
         cnt_d = 8'(WIDTH - 1);
      end else if (cnt_q != 8'h00) begin
         cnt_d = cnt_q - 8'h01;
      end
      pulse_d = shot.trig | (cnt_q != 8'h00);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
         pulse_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pulse_q <= pulse_d;
      end
   end

   assign shot.pulse = pulse_q;

endmodule : qrgs_oneshot

// ### bench/qrgs_sequencer_props.sv
// Port assertions for the gate sequencer.
// Assumes one pclk domain; bound into every sequencer instance.
`timescale 1ns/1ps
module qrgs_sequencer_props
   import qrgs_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic peak_compare,
   input wire logic demag_compare,
   input wire logic primary_gate_out,
   input wire logic secondary_gate_out,
   input wire logic sense_blank,
   input wire logic [7:0] offset_adjust_code
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] ctrl_q;
   logic [7:0] off_q;
   logic [7:0] maxd_q;
   logic [8:0] on_q;
   logic wr;
   logic off_wr;
   assign wr = psel && penable && pready && pwrite;
   assign off_wr = wr && paddr == OFF_OFFSET;
   // Shadow fields follow completed writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         off_q <= OFFSET_RST;
         maxd_q <= MAXDUTY_RST;
         on_q <= 9'h000;
      end else begin
         if (wr && paddr == OFF_CTRL) ctrl_q <= pwdata[3:0];
         if (wr && paddr == OFF_OFFSET) off_q <= pwdata[7:0];
         if (wr && paddr == OFF_MAXDUTY) maxd_q <= pwdata[7:0];
         on_q <= primary_gate_out ? on_q + 9'h001 : 9'h000;
      end
   end
   no_overlap_a: assert property (!(primary_gate_out && secondary_gate_out))
      else $error("gates overlap");
   pri_dead_a: assert property ($rose(primary_gate_out) |-> !$past(secondary_gate_out))
      else $error("primary on without dead time");
   sec_dead_a: assert property ($rose(secondary_gate_out) |-> !$past(primary_gate_out))
      else $error("secondary on without dead time");
   pri_gated_a: assert property ((!ctrl_q[CTRL_PRI_EN]) [*3] |-> !primary_gate_out)
      else $error("disabled primary driven");
   sec_gated_a: assert property ((!ctrl_q[CTRL_SEC_EN]) [*3] |-> !secondary_gate_out)
      else $error("disabled secondary driven");
   peak_trip_a: assert property ($fell(peak_compare) && primary_gate_out &&
      $past(primary_gate_out, 4) |-> ##[1:6] !primary_gate_out)
      else $error("peak fall did not end on-time");
   off_latch_a: assert property ($fell(primary_gate_out) |-> !primary_gate_out [*3])
      else $error("primary retriggered in same cycle");
   // Limit may drop mid-pulse; the pulse must then end at once
   max_duty_a: assert property (primary_gate_out && on_q >= {1'b0, maxd_q} |=>
      !primary_gate_out)
      else $error("on-time beyond max duty");
   offset_code_a: assert property ($past(off_wr, 2) |->
      offset_adjust_code == off_q)
      else $error("offset code not applied");
   demag_start_a: assert property (ctrl_q[CTRL_QR_MODE] && $fell(demag_compare) &&
      secondary_gate_out && $past(secondary_gate_out, 4) |-> ##[1:8] !secondary_gate_out)
      else $error("demag fall did not restart");
   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait state");
   cover property ($rose(secondary_gate_out));
   cover property (wr && paddr == OFF_OFFSET);
   cover property (ctrl_q[CTRL_QR_MODE] && $fell(demag_compare));
endmodule : qrgs_sequencer_props

bind qrgs_sequencer qrgs_sequencer_props u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .peak_compare, .demag_compare,
   .primary_gate_out, .secondary_gate_out, .sense_blank, .offset_adjust_code);

// ### bench/qrgs_power_stage.sv
// Behavioural switches and comparators at the gate pins.
// Assumes lengths in pclk cycles set by the bench.
`timescale 1ns/1ps
module qrgs_power_stage (
   // Clock
   input wire logic pclk,
   // Gates and lengths
   input wire logic primary_gate_out,
   input wire logic secondary_gate_out,
   input wire logic [7:0] on_len,
   input wire logic [7:0] demag_len,
   // Comparators
   output logic peak_compare,
   output logic demag_compare
);
   logic [7:0] cnt_q = 8'h00;
   initial peak_compare = 1'b0;
   initial demag_compare = 1'b1;
   // Ramp restarts in each dead gap, as current does
   always @(posedge pclk) begin
      cnt_q <= (primary_gate_out || secondary_gate_out) ? cnt_q + 8'h01 : 8'h00;
      peak_compare <= primary_gate_out && cnt_q < on_len;
      demag_compare <= !(secondary_gate_out && cnt_q >= demag_len);
   end
endmodule : qrgs_power_stage

// ### bench/qrgs_sequencer_test.sv
// Self-checking bench for the gate sequencer.
// Assumes the power stage model on the comparator pins.
`timescale 1ns/1ps
module qrgs_sequencer_test
   import qrgs_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, peak, demag, pri, sec, blank;
   logic [7:0] code;
   logic [7:0] on_len = 8'h0A;
   logic [7:0] demag_len = 8'h08;
   logic [7:0] exp_off = OFFSET_RST;
   logic [31:0] r, v;
   logic e, prev_p;
   int bad_count, cmp_count, cyc, last_rise, ival, hi, last_hi, sec_seen, md, bhi, last_bhi;
   logic [7:0] adr [6] = '{OFF_CTRL, OFF_DEAD, OFF_BLANK, OFF_OFFSET, OFF_PERIOD, OFF_MAXDUTY};
   logic [7:0] rst [6] = '{8'(CTRL_RST), 8'(DEAD_RST), 8'(BLANK_RST), OFFSET_RST, PERIOD_RST,
      MAXDUTY_RST};
   qrgs_sequencer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .peak_compare(peak), .demag_compare(demag), .primary_gate_out(pri),
      .secondary_gate_out(sec), .sense_blank(blank), .offset_adjust_code(code));
   qrgs_power_stage u_stage (.pclk, .primary_gate_out(pri), .secondary_gate_out(sec),
      .on_len, .demag_len, .peak_compare(peak), .demag_compare(demag));
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (pri && !prev_p) begin
         ival = cyc - last_rise;
         last_rise = cyc;
         hi = 0;
      end
      if (pri) hi++;
      if (!pri && prev_p) last_hi = hi;
      if (sec) sec_seen++;
      if (blank) bhi++;
      else if (bhi != 0) begin
         last_bhi = bhi;
         bhi = 0;
      end
      prev_p = pri;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      cmp_count++;
      if (g !== x) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
      end
   endtask : chk
   // Called right after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      chk(n < 20, 1, "no pready");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   function automatic logic [31:0] fold(input logic [7:0] a, input logic [31:0] d);
      case (a)
         OFF_CTRL, OFF_DEAD: fold = {28'h0, d[3:0]};
         OFF_BLANK: fold = {30'h0, d[1:0]};
         default: fold = {24'h0, d[7:0]};
      endcase
   endfunction : fold
   task automatic run(input logic [3:0] c, input int n, input string m);
      apb(1'b1, OFF_CTRL, {28'h0, c});
      // Gate launched under the old control was counted at the last apb edge; this edge already sees the new control
      @(posedge pclk);
      sec_seen = 0;
      repeat (n) @(posedge pclk);
      $display("test %s done", m);
   endtask : run
   initial begin
      #(100 * 20000);
      bad_count++;
      summarize();
   end
   initial begin
      void'($urandom(32175));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, adr[i], 32'h0);
         chk(r, {24'h0, rst[i]}, "reset value");
      end
      apb(1'b1, 8'h1C, 32'hFFFFFFFF);
      apb(1'b0, 8'h1C, 32'h0);
      chk({r[30:0], e}, 32'h1, "unmapped");
      apb(1'b1, OFF_PERIOD, 32'h1);
      apb(1'b0, OFF_PERIOD, 32'h0);
      chk(r, 32'h1, "period raw");
      // Staggered reads see every timer phase; top value is the floored limit
      md = 0;
      for (int k = 0; k < 4; k++) begin
         repeat (k) @(posedge pclk);
         apb(1'b0, OFF_STATUS, 32'h0);
         if (r[15:8] > md) md = r[15:8];
      end
      chk(md, PERIOD_MIN, "period floor");
      for (int i = 0; i < 12; i++) begin
         v = $urandom;
         apb(1'b1, adr[i % 6], v);
         apb(1'b0, adr[i % 6], 32'h0);
         chk(r, fold(adr[i % 6], v), "readback");
         if (adr[i % 6] == OFF_OFFSET) exp_off = v[7:0];
         chk(code, {24'h0, exp_off}, "offset code");
      end
      apb(1'b1, OFF_OFFSET, 32'h5A);
      apb(1'b1, OFF_BLANK, 32'h3);
      apb(1'b1, OFF_DEAD, $urandom % 16);
      apb(1'b1, OFF_PERIOD, 32'h3F);
      apb(1'b1, OFF_MAXDUTY, 32'h80);
      on_len = 8'(8 + $urandom % 16);
      run(4'h3, 400, "fixed");
      chk(ival, 64, "fixed period");
      chk(code, 32'h5A, "offset held");
      chk(last_bhi, BLANK3_CYC, "blank width");
      run(4'h1, 300, "pri only");
      chk(sec_seen, 0, "secondary disabled");
      md = 4 + $urandom % 16;
      on_len = 8'hFF;
      apb(1'b1, OFF_MAXDUTY, md);
      run(4'h3, 300, "max duty");
      chk(last_hi >= md && last_hi <= md + 2, 1, "max duty");
      apb(1'b1, OFF_DEAD, 32'h1);
      apb(1'b1, OFF_PERIOD, 32'hFF);
      on_len = 8'h0A;
      demag_len = 8'(5 + $urandom % 10);
      run(4'hF, 400, "quasi-resonant");
      chk(ival < 60 && sec_seen > 0, 1, "demag restart");
      demag_len = 8'hFF;
      apb(1'b1, OFF_PERIOD, 32'h3F);
      run(4'hF, 500, "watchdog");
      chk(ival >= 64 && ival <= 124, 1, "watchdog restart");
      summarize();
   end
endmodule : qrgs_sequencer_test
